// ### rtl/pin_state_pkg.sv
// Purpose: constants for byte-lane strobes and bus pin direction control
// Assumes: one bus clock domain, active-high asynchronous core reset
// Notes:   width and size codes are shared by the core sequencer
package pin_state_pkg;
  // Region width codes
  localparam logic [1:0] WIDTH_8  = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;
  // Transfer size codes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // Reset pin low time, in bus clocks
  localparam logic [3:0] RESET_MIN_CYCLES = 4'h8;
  localparam int         WORD_ADDR_W      = 22;
  typedef enum logic {BUS_OWNED, BUS_GRANTED} bus_state_e;
endpackage

// ### rtl/bus_byte_lane_and_pin_state.sv
// Purpose: byte-lane strobe encoding and pin drive/float/input control
// Assumes: all inputs but the asynchronous RST synchronous to CORE_CLK; pin OE_N low means driving
// Notes:   active-low pin levels are produced here, core side is active high
module bus_byte_lane_and_pin_state (
  // Clock and reset
  input  wire logic                                  CORE_CLK,
  input  wire logic                                  RST,
  // Core transfer request
  input  wire logic                                  XFER_ACTIVE,
  input  wire logic                                  XFER_WRITE,
  input  wire logic [1:0]                            XFER_WIDTH,
  input  wire logic [1:0]                            XFER_SIZE,
  input  wire logic [1:0]                            XFER_BYTE_ADDR,
  input  wire logic [pin_state_pkg::WORD_ADDR_W-1:0] XFER_WORD_ADDR,
  input  wire logic [31:0]                           XFER_WDATA,
  input  wire logic                                  WE_STROBE,
  input  wire logic                                  OE_STROBE,
  input  wire logic                                  LAST_BEAT,
  input  wire logic [7:0]                            CS_ACTIVE,
  // Operable side functions
  input  wire logic [3:0]                            RAS_ACTIVE,
  input  wire logic [3:0]                            CAS_ACTIVE,
  input  wire logic                                  DRAM_OE_ACT,
  input  wire logic                                  DRAM_WE_ACT,
  input  wire logic [3:0]                            DMA_ACK_ACT,
  input  wire logic [3:0]                            TC_ACT,
  input  wire logic                                  BUS_REQ_ACT,
  input  wire logic                                  ERROR_ACT,
  input  wire logic                                  SER_TX_BIT,
  // Configuration
  input  wire logic                                  BYTE_ENABLE_MODE,
  input  wire logic                                  CAS_HOLD_FLOAT,
  input  wire logic [3:0]                            CS_RAS_SEL,
  input  wire logic                                  HOLD_REQ,
  input  wire logic                                  SYS_RESET_REQ,
  // Status
  output      logic                                  RESET_ACTIVE,
  output      logic                                  BUS_GRANT_ACK,
  output      logic [pin_state_pkg::WORD_ADDR_W-1:0] EXT_ADDR,
  output      logic [3:0]                            EXT_LANE_ADDR,
  output      logic [1:0]                            EXT_TRANSFER_SIZE,
  output      logic                                  EXT_WRITE,
  // Address pins
  output      logic [pin_state_pkg::WORD_ADDR_W-1:0] ADDR_PIN_O,
  output      logic                                  ADDR_PIN_OE_N,
  input  wire logic [pin_state_pkg::WORD_ADDR_W-1:0] ADDR_PIN_I,
  // Data pins
  output      logic [31:0]                           DATA_PIN_O,
  output      logic                                  DATA_PIN_OE_N,
  input  wire logic [31:0]                           DATA_PIN_I,
  // Chip selects, 4..7 shared with row strobes
  output      logic [7:0]                            CHIP_SELECTS_N_O,
  output      logic [7:0]                            CHIP_SELECTS_OE_N,
  // Output enable / size 1 / last beat pin
  output      logic                                  OE_PIN_O,
  output      logic                                  OE_PIN_OE_N,
  input  wire logic                                  OE_PIN_I,
  // Read/write pin
  output      logic                                  RW_PIN_O,
  output      logic                                  RW_PIN_OE_N,
  input  wire logic                                  RW_PIN_I,
  // Byte lane strobes
  output      logic [3:0]                            BYTE_LANE_STROBES_O,
  output      logic                                  BYTE_LANE_STROBES_OE_N,
  input  wire logic [3:0]                            BYTE_LANE_STROBES_I,
  // Terminal count pins
  output      logic [3:0]                            TC_PIN_O,
  output      logic [3:0]                            TC_PIN_OE_N,
  input  wire logic [3:0]                            TC_PIN_I,
  // Reset pin
  output      logic                                  RESET_PIN_O,
  output      logic                                  RESET_PIN_OE_N,
  input  wire logic                                  RESET_PIN_I,
  // Plain outputs
  output      logic [3:0]                            COLUMN_STROBES_N,
  output      logic                                  COLUMN_STROBES_OE_N,
  output      logic [3:0]                            DMA_ACK_N,
  output      logic                                  DRAM_OE_N,
  output      logic                                  DRAM_WE_N,
  output      logic                                  SERIAL_TX,
  output      logic                                  BUS_REQ,
  output      logic                                  ERROR_OUT
);
  import pin_state_pkg::*;

  // Active-low lane strobes for one transfer
  // Strobes 2 and 3 carry A30 and A31 below 32-bit width
  function automatic logic [3:0] lane_code(input logic [1:0] w, input logic [1:0] s,
                                           input logic [1:0] a, input logic en);
    logic [3:0] sel;
    sel = 4'h0;
    lane_code = 4'hf;
    if (w == WIDTH_8) begin
      lane_code = {a[0], a[1], 1'b1, ~en};
    end else if (w == WIDTH_16) begin
      // Halfword takes both lanes; a byte picks one by A31
      sel[0] = (s != SIZE_BYTE) | ~a[0];
      sel[1] = (s != SIZE_BYTE) | a[0];
      lane_code = {a[0], a[1], ~(en & sel[1]), ~(en & sel[0])};
    end else begin
      if (s == SIZE_WORD) sel = 4'hf;
      else if (s == SIZE_HALF) sel = a[1] ? 4'hc : 4'h3;
      else sel = 4'h1 << a;
      lane_code = ~(sel & {4{en}});
    end
  endfunction

  bus_state_e bus_state_r;
  bus_state_e bus_state_nxt;
  logic [3:0] low_cnt_r;
  logic [3:0] self_cnt_r;
  logic       ext_rst_r;
  logic       in_reset;
  logic       granted;
  logic       lane_en;
  logic [3:0] lanes_nxt;
  logic       oe_pin_nxt;
  logic [3:0] lanes_r;
  logic       oe_pin_r;
  logic [31:0] wdata_r;
  logic [WORD_ADDR_W-1:0] addr_r;

  // Reset sources and grant state
  assign in_reset      = RST | ext_rst_r;
  assign granted       = (bus_state_r == BUS_GRANTED);
  assign RESET_ACTIVE  = in_reset;
  assign BUS_GRANT_ACK = granted & ~in_reset;
  // Grant only between transfers so a cycle is never cut off mid-way
  assign bus_state_nxt = (bus_state_r == BUS_OWNED) ?
                         ((HOLD_REQ & ~XFER_ACTIVE) ? BUS_GRANTED : BUS_OWNED) :
                         (HOLD_REQ ? BUS_GRANTED : BUS_OWNED);

  // Low-pin qualification; shorter pulses are glitches, not resets
  // Counter saturates so a long low pin never wraps back
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      low_cnt_r <= 4'h0;
      ext_rst_r <= 1'b0;
    end else begin
      low_cnt_r <= RESET_PIN_I ? 4'h0 :
                   (low_cnt_r == RESET_MIN_CYCLES) ? low_cnt_r : low_cnt_r + 4'h1;
      ext_rst_r <= ~RESET_PIN_I & (low_cnt_r >= RESET_MIN_CYCLES - 4'h1);
    end
  end

  // Self-initiated reset pulse width
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) self_cnt_r <= 4'h0;
    else if (SYS_RESET_REQ && self_cnt_r == 4'h0) self_cnt_r <= RESET_MIN_CYCLES;
    else if (self_cnt_r != 4'h0) self_cnt_r <= self_cnt_r - 4'h1;
  end

  // Grant state; any reset returns the bus to the device
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) bus_state_r <= BUS_OWNED;
    else if (ext_rst_r) bus_state_r <= BUS_OWNED;
    else bus_state_r <= bus_state_nxt;
  end

  // Lane and output-enable pin contents
  assign lane_en    = BYTE_ENABLE_MODE ? (WE_STROBE | OE_STROBE) : WE_STROBE;
  assign lanes_nxt  = lane_code(XFER_WIDTH, XFER_SIZE, XFER_BYTE_ADDR, lane_en);
  assign oe_pin_nxt = BYTE_ENABLE_MODE ? ~LAST_BEAT : ~OE_STROBE;

  // Registered pin data, idle-inactive after reset
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      lanes_r  <= 4'hf;
      oe_pin_r <= 1'b1;
      wdata_r  <= 32'h0;
      addr_r   <= '0;
    end else begin
      lanes_r  <= lanes_nxt;
      oe_pin_r <= oe_pin_nxt;
      wdata_r  <= XFER_WDATA;
      addr_r   <= XFER_WORD_ADDR;
    end
  end

  // Sample the external master's cycle while it owns the bus
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      EXT_ADDR          <= '0;
      EXT_LANE_ADDR     <= 4'h0;
      EXT_TRANSFER_SIZE <= 2'h0;
      EXT_WRITE         <= 1'b0;
    end else if (BUS_GRANT_ACK) begin
      EXT_ADDR          <= ADDR_PIN_I;
      EXT_LANE_ADDR     <= BYTE_LANE_STROBES_I;
      EXT_TRANSFER_SIZE <= {OE_PIN_I, TC_PIN_I[3]};
      EXT_WRITE         <= ~RW_PIN_I;
    end
  end

  // Bus pins: float in reset or grant, data only during writes
  assign ADDR_PIN_O             = addr_r;
  assign ADDR_PIN_OE_N          = in_reset | granted;
  assign DATA_PIN_O             = wdata_r;
  assign DATA_PIN_OE_N          = in_reset | granted | ~(XFER_ACTIVE & XFER_WRITE);
  assign OE_PIN_O               = oe_pin_r;
  assign OE_PIN_OE_N            = in_reset | granted;
  assign RW_PIN_O               = ~XFER_WRITE;
  assign RW_PIN_OE_N            = in_reset | granted;
  assign BYTE_LANE_STROBES_O    = lanes_r;
  assign BYTE_LANE_STROBES_OE_N = in_reset | granted;

  // Chip selects; shared pins stay driven in grant when carrying row strobes
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_cs
      if (gi < 4) begin : g_plain
        assign CHIP_SELECTS_N_O[gi]  = ~CS_ACTIVE[gi];
        assign CHIP_SELECTS_OE_N[gi] = in_reset | granted;
      end else begin : g_shared
        assign CHIP_SELECTS_N_O[gi]  = CS_RAS_SEL[gi-4] ? ~RAS_ACTIVE[gi-4] : ~CS_ACTIVE[gi];
        assign CHIP_SELECTS_OE_N[gi] = in_reset | (granted & ~CS_RAS_SEL[gi-4]);
      end
    end
    // Terminal count: 0..2 parked high in grant, 3 becomes size input
    for (gi = 0; gi < 4; gi++) begin : g_tc
      if (gi < 3) begin : g_low
        assign TC_PIN_O[gi] = granted ? 1'b1 : ~TC_ACT[gi];
        assign TC_PIN_OE_N[gi] = in_reset;
      end else begin : g_top
        assign TC_PIN_O[gi] = ~TC_ACT[gi];
        assign TC_PIN_OE_N[gi] = in_reset | granted;
      end
    end
  endgenerate

  // Reset pin driven low only for a self-initiated reset
  assign RESET_PIN_O    = 1'b0;
  assign RESET_PIN_OE_N = (self_cnt_r == 4'h0);

  // Operable outputs; reset parks them inactive
  assign COLUMN_STROBES_N    = in_reset ? 4'hf : ~CAS_ACTIVE;
  assign COLUMN_STROBES_OE_N = ~in_reset & granted & CAS_HOLD_FLOAT;
  assign DMA_ACK_N           = (in_reset | granted) ? 4'hf : ~DMA_ACK_ACT;
  assign DRAM_OE_N           = in_reset | ~DRAM_OE_ACT;
  assign DRAM_WE_N           = in_reset | ~DRAM_WE_ACT;
  assign SERIAL_TX           = in_reset | SER_TX_BIT;
  assign BUS_REQ             = ~in_reset & BUS_REQ_ACT;
  assign ERROR_OUT           = ~in_reset & ERROR_ACT;

  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  chk_reset_qualify: assert property (ext_rst_r |-> $past(!RESET_PIN_I, 8))
    else $error("reset accepted before eight low clocks");
  chk_reset_float: assert property (ext_rst_r |-> ADDR_PIN_OE_N && DATA_PIN_OE_N
    && BYTE_LANE_STROBES_OE_N && &TC_PIN_OE_N && &CHIP_SELECTS_OE_N
    && COLUMN_STROBES_N == 4'hf && !BUS_REQ && !BUS_GRANT_ACK)
    else $error("pin not parked during reset");
  chk_self_reset: assert property ($rose(!RESET_PIN_OE_N) |-> (!RESET_PIN_OE_N)[*8]
    ##1 RESET_PIN_OE_N)
    else $error("self reset drive length wrong");
  chk_grant_float: assert property (BUS_GRANT_ACK |-> DATA_PIN_OE_N && ADDR_PIN_OE_N
    && RW_PIN_OE_N && OE_PIN_OE_N && &CHIP_SELECTS_OE_N[3:0])
    else $error("bus pin driven under grant");
  chk_grant_size: assert property (BUS_GRANT_ACK |=>
    EXT_TRANSFER_SIZE == {$past(OE_PIN_I), $past(TC_PIN_I[3])})
    else $error("external size not sampled");
  chk_grant_tc: assert property (BUS_GRANT_ACK |-> TC_PIN_O[2:0] == 3'h7
    && TC_PIN_OE_N == 4'h8)
    else $error("count pins wrong under grant");
  chk_grant_lanes: assert property (BUS_GRANT_ACK |=> EXT_LANE_ADDR
    == $past(BYTE_LANE_STROBES_I))
    else $error("lane address not sampled");
  chk_shared_cs: assert property (BUS_GRANT_ACK && CS_RAS_SEL[0] |-> !CHIP_SELECTS_OE_N[4])
    else $error("row strobe floated under grant");
  chk_cas_float: assert property (BUS_GRANT_ACK |-> COLUMN_STROBES_OE_N == CAS_HOLD_FLOAT)
    else $error("column strobe direction wrong");
  chk_lane_8bit: assert property (XFER_WIDTH == WIDTH_8 |=> BYTE_LANE_STROBES_O[1]
    && BYTE_LANE_STROBES_O[3:2] == {$past(XFER_BYTE_ADDR[0]), $past(XFER_BYTE_ADDR[1])})
    else $error("8-bit lane code wrong");
  chk_lane_16half: assert property (XFER_WIDTH == WIDTH_16 && XFER_SIZE == SIZE_HALF
    && WE_STROBE |=> BYTE_LANE_STROBES_O[1:0] == 2'h0)
    else $error("16-bit halfword lanes wrong");
  chk_lane_32word: assert property (XFER_WIDTH == WIDTH_32 && XFER_SIZE == SIZE_WORD
    && WE_STROBE |=> BYTE_LANE_STROBES_O == 4'h0)
    else $error("32-bit word lanes wrong");
  chk_be_mode: assert property (BYTE_ENABLE_MODE && !WE_STROBE && OE_STROBE
    && XFER_WIDTH == WIDTH_32 && XFER_SIZE == SIZE_WORD |=> BYTE_LANE_STROBES_O == 4'h0
    && OE_PIN_O == !$past(LAST_BEAT))
    else $error("byte enable mode wrong");
  chk_grant_idle: assert property ($rose(bus_state_r == BUS_GRANTED) |-> $past(!XFER_ACTIVE))
    else $error("grant during device transfer");

  // Grant release, operable outputs and pin reset parking
  chk_grant_release: assert property (BUS_GRANT_ACK && !HOLD_REQ |=> !BUS_GRANT_ACK)
    else $error("grant kept after request dropped");
  chk_grant_restore: assert property ($fell(BUS_GRANT_ACK) && !ext_rst_r |-> !ADDR_PIN_OE_N
    && !RW_PIN_OE_N && !BYTE_LANE_STROBES_OE_N)
    else $error("pins not driven after grant ends");
  chk_grant_operable: assert property (BUS_GRANT_ACK |-> DRAM_OE_N == !DRAM_OE_ACT
    && DRAM_WE_N == !DRAM_WE_ACT && BUS_REQ == BUS_REQ_ACT && ERROR_OUT == ERROR_ACT
    && SERIAL_TX == SER_TX_BIT)
    else $error("operable output frozen under grant");
  chk_pin_reset_park: assert property (ext_rst_r |-> DMA_ACK_N == 4'hf && DRAM_OE_N && DRAM_WE_N
    && SERIAL_TX && !ERROR_OUT && OE_PIN_OE_N && RW_PIN_OE_N)
    else $error("output not inactive during pin reset");
  chk_reset_drop_grant: assert property (ext_rst_r |=> bus_state_r == BUS_OWNED)
    else $error("grant survived pin reset");
endmodule

// ### sim/bus_far_side_model.sv
// Purpose: far side of the bus pins: external master, reset source, pin resolution
// Assumes: design OE_N low means the design drives; reset pin has a pull-up
// Notes:   released lines other than the reset pin toggle every cycle while m_en is low, so stale values never look valid
module bus_far_side_model (
  // Clock
  input  wire logic        CORE_CLK,
  // Design pin drives
  input  wire logic [21:0] ADDR_PIN_O,
  input  wire logic        ADDR_PIN_OE_N,
  input  wire logic [31:0] DATA_PIN_O,
  input  wire logic        DATA_PIN_OE_N,
  input  wire logic        OE_PIN_O,
  input  wire logic        OE_PIN_OE_N,
  input  wire logic        RW_PIN_O,
  input  wire logic        RW_PIN_OE_N,
  input  wire logic [3:0]  BYTE_LANE_STROBES_O,
  input  wire logic        BYTE_LANE_STROBES_OE_N,
  input  wire logic [3:0]  TC_PIN_O,
  input  wire logic [3:0]  TC_PIN_OE_N,
  input  wire logic        RESET_PIN_O,
  input  wire logic        RESET_PIN_OE_N,
  // External master and reset source controls
  input  wire logic        m_en,
  input  wire logic [21:0] m_addr,
  input  wire logic [31:0] m_data,
  input  wire logic [3:0]  m_lanes,
  input  wire logic [1:0]  m_size,
  input  wire logic        m_rw,
  input  wire logic        rst_low,
  // Resolved pin levels
  output      logic [21:0] ADDR_PIN_I,
  output      logic [31:0] DATA_PIN_I,
  output      logic        OE_PIN_I,
  output      logic        RW_PIN_I,
  output      logic [3:0]  BYTE_LANE_STROBES_I,
  output      logic [3:0]  TC_PIN_I,
  output      logic        RESET_PIN_I
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       alt = 1'b0;
  logic [3:0] tc_ext;
  // Floating pattern, changes every cycle
  always @(posedge CORE_CLK) begin
    alt <= ~alt;
  end
  // Master drives data, address, size and lanes only while it owns the bus
  assign tc_ext = m_en ? {m_size[0], 3'h7} : {4{alt}};
  assign ADDR_PIN_I = !ADDR_PIN_OE_N ? ADDR_PIN_O : (m_en ? m_addr : {22{alt}});
  assign DATA_PIN_I = !DATA_PIN_OE_N ? DATA_PIN_O : (m_en ? m_data : {32{alt}});
  assign OE_PIN_I = !OE_PIN_OE_N ? OE_PIN_O : (m_en ? m_size[1] : alt);
  assign RW_PIN_I = !RW_PIN_OE_N ? RW_PIN_O : (m_en ? m_rw : alt);
  assign BYTE_LANE_STROBES_I = !BYTE_LANE_STROBES_OE_N ? BYTE_LANE_STROBES_O
                             : (m_en ? m_lanes : {4{alt}});
  assign TC_PIN_I = (~TC_PIN_OE_N & TC_PIN_O) | (TC_PIN_OE_N & tc_ext);
  // Reset held low by the system for as long as the bench asks; pull-up otherwise
  assign RESET_PIN_I = !RESET_PIN_OE_N ? RESET_PIN_O : !rst_low;
endmodule

// ### sim/bus_byte_lane_and_pin_state_tb.sv
// Purpose: self-checking bench for lane strobes and pin drive states
// Assumes: inputs change 1 ns after the rising edge; strobes lag one cycle
// Notes:   ordinary lane encodings in a table, grant and resets by hand
module bus_byte_lane_and_pin_state_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pin_state_pkg::*;
  logic CORE_CLK = 1'b0, RST = 1'b1, XFER_ACTIVE, XFER_WRITE, WE_STROBE, OE_STROBE, LAST_BEAT;
  logic DRAM_OE_ACT, DRAM_WE_ACT, BUS_REQ_ACT, ERROR_ACT, SER_TX_BIT, BYTE_ENABLE_MODE;
  logic CAS_HOLD_FLOAT, HOLD_REQ, SYS_RESET_REQ, m_en, m_rw, rst_low;
  logic [1:0] XFER_WIDTH, XFER_SIZE, XFER_BYTE_ADDR, EXT_TRANSFER_SIZE, m_size;
  logic [WORD_ADDR_W-1:0] XFER_WORD_ADDR, EXT_ADDR, ADDR_PIN_O, ADDR_PIN_I, m_addr;
  logic [31:0] XFER_WDATA, DATA_PIN_O, DATA_PIN_I, m_data;
  logic [7:0] CS_ACTIVE, CHIP_SELECTS_N_O, CHIP_SELECTS_OE_N;
  logic [3:0] RAS_ACTIVE, CAS_ACTIVE, DMA_ACK_ACT, TC_ACT, CS_RAS_SEL, EXT_LANE_ADDR, m_lanes;
  logic [3:0] BYTE_LANE_STROBES_O, BYTE_LANE_STROBES_I, TC_PIN_O, TC_PIN_OE_N, TC_PIN_I;
  logic [3:0] COLUMN_STROBES_N, DMA_ACK_N;
  logic RESET_ACTIVE, BUS_GRANT_ACK, EXT_WRITE, ADDR_PIN_OE_N, DATA_PIN_OE_N, OE_PIN_O;
  logic OE_PIN_OE_N, OE_PIN_I, RW_PIN_O, RW_PIN_OE_N, RW_PIN_I, BYTE_LANE_STROBES_OE_N;
  logic RESET_PIN_O, RESET_PIN_OE_N, RESET_PIN_I, COLUMN_STROBES_OE_N, DRAM_OE_N, DRAM_WE_N;
  logic SERIAL_TX, BUS_REQ, ERROR_OUT;
  int n_fail = 0, compares = 0, cycles = 0, n;
  // Row: width, size, byte address, {we, oe, byte-enable mode}, lanes, OE pin
  logic [13:0] rows [20] = '{
    {WIDTH_8, SIZE_BYTE, 2'h0, 3'h4, 4'h2, 1'h1}, {WIDTH_8, SIZE_BYTE, 2'h1, 3'h4, 4'ha, 1'h1},
    {WIDTH_8, SIZE_BYTE, 2'h2, 3'h4, 4'h6, 1'h1}, {WIDTH_8, SIZE_BYTE, 2'h3, 3'h4, 4'he, 1'h1},
    {WIDTH_16, SIZE_HALF, 2'h0, 3'h4, 4'h0, 1'h1}, {WIDTH_16, SIZE_HALF, 2'h2, 3'h4, 4'h4, 1'h1},
    {WIDTH_16, SIZE_BYTE, 2'h0, 3'h4, 4'h2, 1'h1}, {WIDTH_16, SIZE_BYTE, 2'h1, 3'h4, 4'h9, 1'h1},
    {WIDTH_16, SIZE_BYTE, 2'h2, 3'h4, 4'h6, 1'h1}, {WIDTH_16, SIZE_BYTE, 2'h3, 3'h4, 4'hd, 1'h1},
    {WIDTH_32, SIZE_WORD, 2'h0, 3'h4, 4'h0, 1'h1}, {WIDTH_32, SIZE_HALF, 2'h0, 3'h4, 4'hc, 1'h1},
    {WIDTH_32, SIZE_HALF, 2'h2, 3'h4, 4'h3, 1'h1}, {WIDTH_32, SIZE_BYTE, 2'h0, 3'h4, 4'he, 1'h1},
    {WIDTH_32, SIZE_BYTE, 2'h1, 3'h4, 4'hd, 1'h1}, {WIDTH_32, SIZE_BYTE, 2'h2, 3'h4, 4'hb, 1'h1},
    {WIDTH_32, SIZE_BYTE, 2'h3, 3'h4, 4'h7, 1'h1}, {WIDTH_32, SIZE_WORD, 2'h0, 3'h2, 4'hf, 1'h0},
    {WIDTH_32, SIZE_HALF, 2'h2, 3'h3, 4'h3, 1'h0},
    {WIDTH_32, SIZE_WORD, 2'h0, 3'h3, 4'h0, 1'h0}};

  bus_byte_lane_and_pin_state i_bus_byte_lane_and_pin_state (.*);
  bus_far_side_model i_bus_far_side_model (.*);

  // Clock and hang guard; the ceiling is well above the planned sequence
  always #4 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic tick;
    @(posedge CORE_CLK);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    // Operable functions all active and a transfer running so reset must visibly override them
    {XFER_ACTIVE, XFER_WRITE, WE_STROBE, OE_STROBE, LAST_BEAT} = 5'h15;
    {DRAM_OE_ACT, DRAM_WE_ACT, BUS_REQ_ACT, ERROR_ACT, SER_TX_BIT} = 5'h1e;
    {BYTE_ENABLE_MODE, CAS_HOLD_FLOAT, HOLD_REQ, SYS_RESET_REQ} = 4'h0;
    {m_en, m_rw, rst_low, m_size, m_lanes, m_addr, m_data} = '0;
    {XFER_WIDTH, XFER_SIZE, XFER_BYTE_ADDR} = 6'h0;
    {XFER_WORD_ADDR, XFER_WDATA} = '0;
    {CS_ACTIVE, RAS_ACTIVE, CAS_ACTIVE, DMA_ACK_ACT, TC_ACT, CS_RAS_SEL} = 28'hfffffff;
    repeat (3) tick();
    chk({ADDR_PIN_OE_N, DATA_PIN_OE_N, OE_PIN_OE_N, RW_PIN_OE_N}, 4'hf);
    chk({BYTE_LANE_STROBES_OE_N, CHIP_SELECTS_OE_N, TC_PIN_OE_N}, 13'h1fff);
    chk({COLUMN_STROBES_N, DMA_ACK_N, DRAM_OE_N, DRAM_WE_N, SERIAL_TX}, 11'h7ff);
    chk({BUS_REQ, ERROR_OUT, BUS_GRANT_ACK}, 3'h0);
    chk(RESET_PIN_OE_N, 1'h1);
    tick();
    RST = 1'b0;
    // Lane encodings, one row a cycle, back to back
    for (int i = 0; i < 20; i++) begin
      {XFER_WIDTH, XFER_SIZE, XFER_BYTE_ADDR, WE_STROBE, OE_STROBE, BYTE_ENABLE_MODE} = rows[i][13:5];
      XFER_WRITE = WE_STROBE;
      XFER_WORD_ADDR = 22'h2aa55 + 22'(i);
      tick();
      chk(BYTE_LANE_STROBES_O, rows[i][4:1]);
      chk(OE_PIN_O, rows[i][0]);
      if (XFER_WIDTH == WIDTH_32) chk(ADDR_PIN_O, 22'h2aa55 + 22'(i));
    end
    // Grant is held off while a device transfer runs
    HOLD_REQ = 1'b1;
    {WE_STROBE, OE_STROBE, BYTE_ENABLE_MODE, CS_RAS_SEL, CAS_HOLD_FLOAT} = 8'h0b;
    RAS_ACTIVE = 4'h4;
    repeat (2) tick();
    chk(BUS_GRANT_ACK, 1'h0);
    XFER_ACTIVE = 1'b0;
    tick();
    chk(BUS_GRANT_ACK, 1'h1);
    {m_en, m_rw, m_size, m_lanes, m_addr} = {4'h9, 4'h9, 22'h155aa};
    tick();
    chk(DATA_PIN_OE_N, 1'h1);
    chk({ADDR_PIN_OE_N, RW_PIN_OE_N, CHIP_SELECTS_OE_N}, 10'h3af);
    chk({OE_PIN_OE_N, EXT_TRANSFER_SIZE}, 3'h5);
    chk({TC_PIN_OE_N, TC_PIN_O[2:0]}, 7'h47);
    chk({BYTE_LANE_STROBES_OE_N, EXT_LANE_ADDR}, 5'h19);
    chk({EXT_ADDR, EXT_WRITE}, {22'h155aa, 1'h1});
    chk({CHIP_SELECTS_N_O, DMA_ACK_N}, 12'h10f);
    chk({COLUMN_STROBES_OE_N, DRAM_OE_N, BUS_REQ}, 3'h5);
    CAS_HOLD_FLOAT = 1'b0;
    #1;
    chk(COLUMN_STROBES_OE_N, 1'h0);
    {HOLD_REQ, m_en, XFER_ACTIVE, XFER_WRITE} = 4'h3;
    XFER_WDATA = 32'hc3a55a3c;
    tick();
    chk({BUS_GRANT_ACK, BYTE_LANE_STROBES_OE_N, DATA_PIN_OE_N}, 3'h0);
    chk(DATA_PIN_O, 32'hc3a55a3c);
    chk(RW_PIN_O, 1'h0);
    // Pin reset qualifies only after eight low samples
    rst_low = 1'b1;
    repeat (7) tick();
    chk(RESET_ACTIVE, 1'h0);
    tick();
    chk({RESET_ACTIVE, BUS_REQ, ERROR_OUT, ADDR_PIN_OE_N}, 4'h9);
    rst_low = 1'b0;
    repeat (2) tick();
    chk(RESET_ACTIVE, 1'h0);
    // Self reset drives our own pin for exactly eight cycles
    SYS_RESET_REQ = 1'b1;
    tick();
    SYS_RESET_REQ = 1'b0;
    n = 0;
    repeat (12) begin
      if (RESET_PIN_OE_N === 1'b0) n++;
      tick();
    end
    chk(n, 8);
    chk(RESET_PIN_O, 1'h0);
    chk(RESET_PIN_OE_N, 1'h1);
    end_of_test();
  end
endmodule
